/* File: dmr_core.sv */
// mode and extended mode register decode with burst column order generation
// What this block does
// - A3 picks sequential or interleaved burst order
// - A2..A0 set burst length 2,4,8
// - sequential offsets count up, wrap in block
// - interleaved offsets are start xor counter
// - A6..A4 code CAS latency 2,3,2.5
// - first read data whole CAS latency plus two cycles after the command cycle
// - A8..A7 test field, 10 resets DLL
// - bank select low mode, high extended
// - all strobes low captures address into register
// - extended A1 selects driver strength
// - extended A0 enables delay-locked loop
// - reprogramming allowed while all banks idle
`timescale 1ns/1ps
`default_nettype none
module dmr_core
   import dmr_pkg::*;
(
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   // command and address bus from the controller
   input  wire logic              cs_b,
   input  wire logic              ras_b,
   input  wire logic              cas_b,
   input  wire logic              we_b,
   input  wire logic              bank_sel_lo,
   input  wire logic              bank_sel_hi,
   input  wire logic [12:0]       addr_bus,
   // decoded settings
   output logic [12:0]            mode_reg,
   output logic [12:0]            ext_reg,
   output logic                   burst_interleaved,
   output logic [3:0]             burst_len,
   output logic [3:0]             cas_half_clocks,
   output logic                   dll_reset_req,
   output logic                   dll_enable,
   output logic                   drive_weak,
   output logic                   config_illegal,
   output logic                   load_busy,
   // burst column order and read data timing
   output logic [9:0]             burst_col,
   output logic                   burst_col_valid,
   output logic                   read_data_start
);
   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   logic       is_load;
   logic       is_read;
   logic [1:0] gap_cnt;
   logic [2:0] bl_code;
   logic [2:0] cl_code;
   logic [2:0] off_mask;
   logic [2:0] start_off;
   logic [2:0] step;
   logic [2:0] next_off;
   logic [9:0] start_col;
   logic [3:0] lat_cnt;
   logic [2:0] cl_whole;
   dmr_state_t state;

   assign is_load = !cs_b && !ras_b && !cas_b && !we_b;
   assign is_read = !cs_b && ras_b && !cas_b && we_b;

   // ----------------------------------------------------------------
   // register capture
   // ----------------------------------------------------------------
   // registers only change on a load addressed to them
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_reg <= MODE_RST;
      end else if (is_load && !bank_sel_lo) begin
         mode_reg <= addr_bus;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_reg <= EXT_RST;
      end else if (is_load && bank_sel_lo) begin
         ext_reg <= addr_bus;
      end
   end

   // busy for the load completion time; commands in it are the controller's fault
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_cnt <= 2'h0;
      end else if (is_load) begin
         gap_cnt <= LOAD_GAP_CYC;
      end else if (gap_cnt != 2'h0) begin
         gap_cnt <= gap_cnt - 2'h1;
      end
   end
   assign load_busy = (gap_cnt != 2'h0);

   // ----------------------------------------------------------------
   // field decode
   // ----------------------------------------------------------------
   assign bl_code           = mode_reg[BL_LSB +: 3];
   assign cl_code           = mode_reg[CL_LSB +: 3];
   assign burst_interleaved = mode_reg[BT_POS];
   assign dll_reset_req     = (mode_reg[TM_LSB +: 2] == TM_DLL_RESET);
   // polarity not defined: high taken as enable and as weak
   assign dll_enable        = ext_reg[DLL_POS];
   assign drive_weak        = ext_reg[DRV_POS];

   always_comb begin
      burst_len = 4'h0;
      off_mask  = 3'h0;
      case (bl_code)
         BL_CODE_2: begin
            burst_len = 4'h2;
            off_mask  = 3'h1;
         end
         BL_CODE_4: begin
            burst_len = 4'h4;
            off_mask  = 3'h3;
         end
         BL_CODE_8: begin
            burst_len = 4'h8;
            off_mask  = 3'h7;
         end
         default: begin
            burst_len = 4'h0;
            off_mask  = 3'h0;
         end
      endcase
   end

   // half-clock units so 2.5 is exact; reserved gives zero
   always_comb begin
      cas_half_clocks = 4'h0;
      cl_whole        = 3'h0;
      case (cl_code)
         CL_CODE_2: begin
            cas_half_clocks = 4'h4;
            cl_whole        = 3'h2;
         end
         CL_CODE_3: begin
            cas_half_clocks = 4'h6;
            cl_whole        = 3'h3;
         end
         CL_CODE_25: begin
            cas_half_clocks = 4'h5;
            cl_whole        = 3'h2;
         end
         default: begin
            cas_half_clocks = 4'h0;
            cl_whole        = 3'h0;
         end
      endcase
   end

   // never guess a behaviour for a reserved code
   assign config_illegal = (burst_len == 4'h0) || (cas_half_clocks == 4'h0)
                           || (mode_reg[TM_LSB +: 2] != TM_NORMAL && !dll_reset_req);

   // ----------------------------------------------------------------
   // read latency and burst sequencing
   // ----------------------------------------------------------------
   // 2.5 cannot be shown on a single edge clock; data starts on the whole part
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state     <= DMR_IDLE;
         lat_cnt   <= 4'h0;
         start_col <= 10'h000;
         step      <= 3'h0;
      end else begin
         case (state)
            DMR_IDLE: begin
               if (is_read && !config_illegal) begin
                  start_col <= addr_bus[COL_W-1:0];
                  lat_cnt   <= {1'b0, cl_whole} - 4'h1;
                  step      <= 3'h0;
                  state     <= DMR_WAIT;
               end
            end
            DMR_WAIT: begin
               if (lat_cnt == 4'h0) begin
                  state <= DMR_BURST;
               end else begin
                  lat_cnt <= lat_cnt - 4'h1;
               end
            end
            DMR_BURST: begin
               if (step == off_mask) begin
                  state <= DMR_IDLE;
               end else begin
                  step <= step + 3'h1;
               end
            end
            default: begin
               state <= DMR_IDLE;
            end
         endcase
      end
   end

   assign start_off = start_col[2:0] & off_mask;
   always_comb begin
      if (burst_interleaved) begin
         next_off = (start_off ^ step) & off_mask;
      end else begin
         next_off = (start_off + step) & off_mask;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         burst_col       <= 10'h000;
         burst_col_valid <= 1'b0;
         read_data_start <= 1'b0;
      end else begin
         burst_col_valid <= (state == DMR_BURST);
         read_data_start <= (state == DMR_BURST) && (step == 3'h0);
         burst_col       <= {start_col[9:3], (start_col[2:0] & ~off_mask) | next_off};
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence load_mode_s;
      is_load && !bank_sel_lo;
   endsequence
   sequence load_ext_s;
      is_load && bank_sel_lo;
   endsequence

   mode_capture_a: assert property (load_mode_s |=> mode_reg == $past(addr_bus))
      else $error("mode register missed a load");
   ext_capture_a: assert property (load_ext_s |=> ext_reg == $past(addr_bus))
      else $error("extended register missed a load");
   mode_hold_a: assert property (!(is_load && !bank_sel_lo) |=> $stable(mode_reg))
      else $error("mode register changed without a load");
   ext_hold_a: assert property (!(is_load && bank_sel_lo) |=> $stable(ext_reg))
      else $error("extended register changed without a load");
   reserved_flag_a: assert property (bl_code == 3'h0 |-> config_illegal)
      else $error("reserved burst length not flagged");
   cl_decode_a: assert property (cl_code == CL_CODE_25 |-> cas_half_clocks == 4'h5)
      else $error("latency 2.5 decoded wrongly");
   // burst state is entered at the edge after the count, so it is seen a cycle later
   read_lat2_a: assert property (state == DMR_IDLE && is_read && !config_illegal && cl_whole == 3'h2
      |-> ##3 (state == DMR_BURST && step == 3'h0))
      else $error("burst not started after latency");
   // checked on the registered column, so a broken output stage is caught too
   seq_wrap_a: assert property (!burst_interleaved && burst_col_valid
      |-> ((burst_col[2:0] - start_off) & off_mask) == $past(step) && burst_col[9:3] == start_col[9:3])
      else $error("sequential offset wrong");
   ilv_order_a: assert property (burst_interleaved && burst_col_valid
      |-> ((burst_col[2:0] ^ start_off) & off_mask) == $past(step))
      else $error("interleaved offset wrong");
   type_bit_a: assert property (load_mode_s ##1 1'b1 |-> burst_interleaved == $past(addr_bus[BT_POS]))
      else $error("burst type not from bit 3");
   dll_reset_a: assert property (dll_reset_req |-> mode_reg[8:7] == 2'b10)
      else $error("dll reset decode wrong");
   gap_a: assert property (is_load |=> load_busy [*2])
      else $error("load busy shorter than two cycles");
endmodule
`default_nettype wire

/* File: dmr_ctrl_model.sv */
// controller model driving the command and address bus
`timescale 1ns/1ps
`default_nettype none
module dmr_ctrl_model (
   // clock
   input  wire logic        sys_clk,
   // command and address bus
   output var  logic        cs_b,
   output var  logic        ras_b,
   output var  logic        cas_b,
   output var  logic        we_b,
   output var  logic        bank_sel_lo,
   output var  logic        bank_sel_hi,
   output var  logic [12:0] addr_bus
);
   // ------------------------------
   // command issue
   // ------------------------------
   initial begin
      {cs_b, ras_b, cas_b, we_b} = 4'hf;
      bank_sel_lo = 1'b0;
      bank_sel_hi = 1'b0;
      addr_bus = 13'h0000;
   end
   // slowest access time the controller has to cover, in ps; plain default
   localparam int ACCESS_TIME_FLOOR_PS = 15000;
   localparam int CLK_PERIOD_PS        = 20000;
   // smallest whole latency whose time still covers the access floor
   function automatic logic [2:0] whole_cl();
      return (2 * CLK_PERIOD_PS >= ACCESS_TIME_FLOOR_PS) ? dmr_pkg::CL_CODE_2 : dmr_pkg::CL_CODE_3;
   endfunction
   // after a command the address and bank_sel_lo show inverted values and the strobes go high, so a stale address never looks valid
   task automatic cmd(input logic [3:0] strobes, input logic bank, input logic rsv, input logic [12:0] addr);
      @(posedge sys_clk);
      {cs_b, ras_b, cas_b, we_b} <= strobes;
      bank_sel_lo <= bank;
      bank_sel_hi <= rsv;
      addr_bus <= addr;
      @(posedge sys_clk);
      {cs_b, ras_b, cas_b, we_b} <= 4'hf;
      bank_sel_lo <= ~bank;
      addr_bus <= ~addr;
   endtask
   task automatic load(input logic bank, input logic rsv, input logic [12:0] addr);
      cmd(4'h0, bank, rsv, addr);
      @(posedge sys_clk);
   endtask
   task automatic read(input logic [12:0] addr);
      cmd(4'h5, 1'b0, 1'b0, addr);
   endtask
endmodule
`default_nettype wire

/* File: dmr_pkg.sv */
// package: field positions, codes and timing for the mode register block
package dmr_pkg;
   // address bus and column address widths in bits
   localparam int unsigned ADDR_W         = 13;
   localparam int unsigned COL_W          = 10;
   // mode register fields
   localparam int unsigned BL_LSB         = 0;
   localparam int unsigned BT_POS         = 3;
   localparam int unsigned CL_LSB         = 4;
   localparam int unsigned TM_LSB         = 7;
   // extended register fields
   localparam int unsigned DLL_POS        = 0;
   localparam int unsigned DRV_POS        = 1;
   // codes
   localparam logic [2:0]  BL_CODE_2      = 3'h1;
   localparam logic [2:0]  BL_CODE_4      = 3'h2;
   localparam logic [2:0]  BL_CODE_8      = 3'h3;
   localparam logic [2:0]  CL_CODE_2      = 3'h2;
   localparam logic [2:0]  CL_CODE_3      = 3'h3;
   localparam logic [2:0]  CL_CODE_25     = 3'h6;
   localparam logic [1:0]  TM_NORMAL      = 2'h0;
   localparam logic [1:0]  TM_DLL_RESET   = 2'h2;
   // values after reset (the device itself has none; this is the model's)
   localparam logic [12:0] MODE_RST       = 13'h0000;
   localparam logic [12:0] EXT_RST        = 13'h0000;
   // load-to-next-command spacing in cycles
   localparam logic [1:0]  LOAD_GAP_CYC   = 2'h2;
   localparam logic [3:0]  CL_HALF_MAX    = 4'h6;
   typedef enum logic [1:0] {
      DMR_IDLE  = 2'b00,
      DMR_WAIT  = 2'b01,
      DMR_BURST = 2'b10
   } dmr_state_t;
endpackage

/* File: dmr_tb.sv */
// self-checking bench for the mode register and burst order block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
   $display("ERROR %s exp %h got %h", nm, e, a); end end
module testbench
   import dmr_pkg::*;
;
   logic        sys_clk, rst_b, cs_b, ras_b, cas_b, we_b, bank_sel_lo, bank_sel_hi;
   logic [12:0] addr_bus, mode_reg, ext_reg, a, ea;
   logic        burst_interleaved, dll_reset_req, dll_enable, drive_weak, config_illegal, load_busy;
   logic [3:0]  burst_len, cas_half_clocks, len;
   logic [9:0]  burst_col, exp_col;
   logic        burst_col_valid, read_data_start;
   logic [2:0]  cl;
   logic [31:0] rnd = 32'h9717c0d6;
   logic [12:0] bad_cfg [4] = '{13'h0122, 13'h0020, 13'h0042, 13'h00a2};
   logic [9:0]  cq [$];
   int          sq [$];
   int          bad_count = 0, cmp_count = 0, cyc = 0, exp_cyc;

   dmr_ctrl_model ctrl (.sys_clk(sys_clk), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
      .bank_sel_lo(bank_sel_lo), .bank_sel_hi(bank_sel_hi), .addr_bus(addr_bus));
   dmr_core dut (.sys_clk(sys_clk), .rst_b(rst_b), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
      .bank_sel_lo(bank_sel_lo), .bank_sel_hi(bank_sel_hi), .addr_bus(addr_bus), .mode_reg(mode_reg),
      .ext_reg(ext_reg), .burst_interleaved(burst_interleaved), .burst_len(burst_len),
      .cas_half_clocks(cas_half_clocks), .dll_reset_req(dll_reset_req), .dll_enable(dll_enable),
      .drive_weak(drive_weak), .config_illegal(config_illegal), .load_busy(load_busy),
      .burst_col(burst_col), .burst_col_valid(burst_col_valid), .read_data_start(read_data_start));

   // ------------------------------
   // clock, reset, helpers
   // ------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      rst_b = 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // read and note the expected columns; first column is due n+2 cycles after the command cycle
   task automatic burst_read(input logic [12:0] ra, input logic il, input logic [3:0] bl, input int n);
      logic [9:0] lo;
      @(negedge sys_clk);
      sq.push_back(cyc + n + 3);
      for (int i = 0; i < bl; i++) begin
         lo = il ? (ra[9:0] ^ i[9:0]) : (ra[9:0] + i[9:0]);
         cq.push_back((ra[9:0] & ~(bl - 10'h1)) | (lo & (bl - 10'h1)));
      end
      ctrl.read(ra);
   endtask
   // bounded wait, then a few idle cycles so a wrongly accepted read would surface
   task automatic drain;
      repeat (40) if (cq.size() != 0) @(negedge sys_clk);
      repeat (8) @(negedge sys_clk);
      `CHK("pending_cols", 0, cq.size())
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count++;
         end_of_test;
      end
   end
   always @(negedge sys_clk) begin
      if (read_data_start === 1'b1) begin
         exp_cyc = (sq.size() != 0) ? sq.pop_front() : -1;
         `CHK("start_cycle", exp_cyc, cyc)
      end
      if (burst_col_valid === 1'b1) begin
         exp_col = (cq.size() != 0) ? cq.pop_front() : ~burst_col;
         `CHK("burst_col", exp_col, burst_col)
      end
   end

   // ------------------------------
   // stimulus
   // ------------------------------
   initial begin
      wait (rst_b === 1'b1);
      @(negedge sys_clk);
      `CHK("mode_rst", MODE_RST, mode_reg)
      // extended register first, as after power-up
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         a = {rnd[12:2], k[1:0]};
         ctrl.load(1'b1, rnd[20], a);
         @(negedge sys_clk);
         `CHK("ext_reg", a, ext_reg)
         `CHK("dll_enable", a[0], dll_enable)
         `CHK("drive_weak", a[1], drive_weak)
         `CHK("mode_kept", MODE_RST, mode_reg)
      end
      ea = a;
      for (int bl = 1; bl < 4; bl++) begin
         for (int bt = 0; bt < 2; bt++) begin
            for (int ci = 0; ci < 3; ci++) begin
               cl = (ci == 0) ? ctrl.whole_cl() : (ci == 1) ? CL_CODE_3 : CL_CODE_25;
               rnd = lfsr(rnd);
               a = {rnd[3:0], TM_NORMAL, cl, bt[0], bl[2:0]};
               ctrl.load(1'b0, rnd[20], a);
               @(negedge sys_clk);
               len = 4'h1 << bl;
               `CHK("burst_len", len, burst_len)
               `CHK("interleaved", bt[0], burst_interleaved)
               `CHK("cas_half", (ci == 0) ? 4'h4 : (ci == 1) ? 4'h6 : 4'h5, cas_half_clocks)
               `CHK("mode_reg", a, mode_reg)
               `CHK("ext_kept", ea, ext_reg)
               rnd = lfsr(rnd);
               burst_read(rnd[12:0], bt[0], len, (ci == 1) ? 3 : 2);
               ctrl.read(~rnd[12:0]);
               drain;
            end
         end
      end
      // reserved codes and test field values; reads under them must be dropped, except under the DLL reset value
      for (int j = 0; j < 4; j++) begin
         ctrl.load(1'b0, 1'b0, bad_cfg[j]);
         @(negedge sys_clk);
         `CHK("illegal", j != 0, config_illegal)
         `CHK("dll_reset", j == 0, dll_reset_req)
         if (j == 0)
            burst_read(13'h0005, 1'b0, 4'h4, 2);
         else
            ctrl.read(13'h0005);
         drain;
      end
      end_of_test;
   end
endmodule
`default_nettype wire
